// [sbrg_pkg.sv]
`default_nettype none
package sbrg_pkg;
  // divisor after reset
  localparam logic [15:0] DIV_RESET = 16'h0002;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  // access enable bit within the line control register
  localparam int LCR_ACCESS_BIT = 7;
  localparam logic [7:0] LCR_RESET = 8'h00;
  // serial select field codes
  typedef enum logic [1:0] {
    SBRG_SEL_NONE = 2'b00,
    SBRG_SEL_UART = 2'b01,
    SBRG_SEL_SPI = 2'b10,
    SBRG_SEL_I2C = 2'b11
  } sbrg_sel_t;
endpackage : sbrg_pkg
`default_nettype wire

// [sbrg_baud_divider.sv]
`default_nettype none
// Function
// R1: count down each clock until one
// R2: at one, reload divisor and pulse
// R3: pulse rate is clock over divisor
// R4: divisor resets to two
// R5: divisor one pulses every clock
// R6: byte write reloads counter, restarts count
// R7: divisor access only when lcr bit7 set
// R8: pulse clocks spi/uart; i2c uses sysclk
// R9: idle when no controller selected
// R10: at most one controller enabled
// R11: software: reset, open, program, close
// R12: select 00 none,01 uart,10 spi,11 i2c
// R13: pulse one clock wide for divisor above one
module sbrg_baud_divider (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // serial select field
  input wire logic [1:0] serial_select_field_i,
  // line control register write port
  input wire logic lcr_wr_i,
  input wire logic [7:0] lcr_wdata_i,
  // divisor byte write strobes and data
  input wire logic divisor_low_wr_i,
  input wire logic divisor_high_wr_i,
  input wire logic [7:0] divisor_wdata_i,
  // status
  output logic [7:0] line_control_register_o,
  output logic [7:0] divisor_low_byte_o,
  output logic [7:0] divisor_high_byte_o,
  output logic [15:0] count_o,
  // controller enables
  output logic uart_en_o,
  output logic spi_en_o,
  output logic i2c_en_o,
  // baud clock enables
  output logic baud_tick_o,
  output logic uart_tick_o,
  output logic spi_tick_o
);

  // ---------------------------------------------------------------
  // line control and divisor latch
  // ---------------------------------------------------------------
  logic [7:0] lcr_reg;
  logic [7:0] div_lo_reg;
  logic [7:0] div_hi_reg;
  logic [15:0] cnt_reg;
  logic tick_reg;
  logic access;
  logic lo_wr;
  logic hi_wr;
  logic active;
  logic [15:0] div_next;

  assign access = lcr_reg[sbrg_pkg::LCR_ACCESS_BIT]; // see R7
  assign lo_wr = divisor_low_wr_i && access; // see R7
  assign hi_wr = divisor_high_wr_i && access; // see R7
  assign active = (sbrg_pkg::sbrg_sel_t'(serial_select_field_i)
                   != sbrg_pkg::SBRG_SEL_NONE); // see R9
  assign div_next = {hi_wr ? divisor_wdata_i : div_hi_reg,
                     lo_wr ? divisor_wdata_i : div_lo_reg};

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      lcr_reg <= sbrg_pkg::LCR_RESET; // see R7
    end
    else if (lcr_wr_i)
    begin
      lcr_reg <= lcr_wdata_i;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      div_lo_reg <= sbrg_pkg::DIV_RESET[7:0]; // see R4
      div_hi_reg <= sbrg_pkg::DIV_RESET[15:8]; // see R4
    end
    else
    begin
      div_lo_reg <= div_next[7:0];
      div_hi_reg <= div_next[15:8];
    end
  end

  // ---------------------------------------------------------------
  // down counter
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      cnt_reg <= sbrg_pkg::DIV_RESET;
      tick_reg <= 1'b0;
    end
    else if (lo_wr || hi_wr)
    begin
      cnt_reg <= div_next; // see R6
      tick_reg <= 1'b0;
    end
    else if (!active)
    begin
      tick_reg <= 1'b0; // see R9
    end
    else if (cnt_reg <= sbrg_pkg::CNT_ONE)
    begin
      // divisor of one reloads one: a tick every clock
      cnt_reg <= {div_hi_reg, div_lo_reg}; // see R2 R5
      tick_reg <= 1'b1; // see R13 R3
    end
    else
    begin
      cnt_reg <= cnt_reg - 16'h0001; // see R1
      tick_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // one-hot decode of the select field
  assign uart_en_o = (serial_select_field_i == sbrg_pkg::SBRG_SEL_UART); // see R12 R10
  assign spi_en_o = (serial_select_field_i == sbrg_pkg::SBRG_SEL_SPI); // see R12 R10
  assign i2c_en_o = (serial_select_field_i == sbrg_pkg::SBRG_SEL_I2C); // see R12 R10
  assign baud_tick_o = tick_reg;
  assign uart_tick_o = tick_reg && uart_en_o; // see R8
  assign spi_tick_o = tick_reg && spi_en_o; // see R8
  assign line_control_register_o = lcr_reg;
  assign divisor_low_byte_o = div_lo_reg;
  assign divisor_high_byte_o = div_hi_reg;
  assign count_o = cnt_reg;

  // ---------------------------------------------------------------
  // period tracking for the rate check
  // ---------------------------------------------------------------
  // cycles since the last tick; a write or idle makes it unusable
  logic [15:0] gap_reg;
  logic gap_valid_reg;

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      gap_reg <= 16'h0000;
      gap_valid_reg <= 1'b0;
    end
    else if (lo_wr || hi_wr || !active)
    begin
      gap_reg <= 16'h0000;
      gap_valid_reg <= 1'b0;
    end
    else if (baud_tick_o)
    begin
      gap_reg <= 16'h0001;
      gap_valid_reg <= 1'b1;
    end
    else
    begin
      gap_reg <= gap_reg + 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // checks: counter and tick
  // ---------------------------------------------------------------
  tick_width_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see R13
    (baud_tick_o && $past(cnt_reg) != sbrg_pkg::CNT_ONE) |=> !baud_tick_o)
    else $error("tick longer than one cycle");

  count_down_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see R1
    (active && !lo_wr && !hi_wr && cnt_reg > 16'h0001) |=> cnt_reg == $past(cnt_reg) - 16'h0001)
    else $error("counter did not decrement");

  reload_pulse_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see R2
    (active && !lo_wr && !hi_wr && cnt_reg == 16'h0001)
    |=> (baud_tick_o && cnt_reg == {div_hi_reg, div_lo_reg}))
    else $error("no reload at end of count");

  write_restart_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see R6
    (lo_wr || hi_wr) |=> (cnt_reg == {div_hi_reg, div_lo_reg} && !baud_tick_o))
    else $error("write did not restart count");

  tick_value_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see R2
    baud_tick_o |-> cnt_reg == {div_hi_reg, div_lo_reg})
    else $error("tick without reload value");

  tick_cause_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see R1
    (active && !lo_wr && !hi_wr && cnt_reg > sbrg_pkg::CNT_ONE) |=> !baud_tick_o)
    else $error("tick before end of count");

  bypass_rate_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see R5
    (active && {div_hi_reg, div_lo_reg} == 16'h0001 && cnt_reg == 16'h0001
     && !lo_wr && !hi_wr) |=> baud_tick_o)
    else $error("divisor one did not tick");

  bypass_steady_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see R5
    (active && !lo_wr && !hi_wr && baud_tick_o
     && {div_hi_reg, div_lo_reg} == sbrg_pkg::CNT_ONE) |=> baud_tick_o)
    else $error("divisor one tick gap");

  period_two_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see R3
    (active && !lo_wr && !hi_wr && baud_tick_o && {div_hi_reg, div_lo_reg} == 16'h0002) ##1
    (active && !lo_wr && !hi_wr) [*2] |-> baud_tick_o)
    else $error("divisor two period wrong");

  rate_gap_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see R3
    (baud_tick_o && gap_valid_reg && {div_hi_reg, div_lo_reg} != 16'h0000)
    |-> gap_reg == {div_hi_reg, div_lo_reg})
    else $error("tick period differs from divisor");

  // ---------------------------------------------------------------
  // checks: registers and access
  // ---------------------------------------------------------------
  lcr_write_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see R7
    lcr_wr_i |=> lcr_reg == $past(lcr_wdata_i))
    else $error("line control write lost");

  lcr_hold_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see R7
    !lcr_wr_i |=> $stable(lcr_reg))
    else $error("line control changed without write");

  gated_access_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see R7
    (!access && !lcr_wr_i) |=> $stable(div_lo_reg) && $stable(div_hi_reg))
    else $error("divisor changed while locked");

  lock_low_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see R7
    (divisor_low_wr_i && !access) |=> $stable(div_lo_reg))
    else $error("locked low byte written");

  lock_high_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see R7
    (divisor_high_wr_i && !access) |=> $stable(div_hi_reg))
    else $error("locked high byte written");

  low_write_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see R6
    lo_wr |=> div_lo_reg == $past(divisor_wdata_i))
    else $error("low byte write lost");

  high_write_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see R6
    hi_wr |=> div_hi_reg == $past(divisor_wdata_i))
    else $error("high byte write lost");

  low_keep_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see R6
    (lo_wr && !hi_wr) |=> $stable(div_hi_reg))
    else $error("low write disturbed high byte");

  high_keep_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see R6
    (hi_wr && !lo_wr) |=> $stable(div_lo_reg))
    else $error("high write disturbed low byte");

  reset_value_a: assert property (@(posedge sys_clk_i) // see R4
    rst_i |=> {div_hi_reg, div_lo_reg} == sbrg_pkg::DIV_RESET && !access)
    else $error("bad reset divisor");

  count_reset_a: assert property (@(posedge sys_clk_i) // see R4
    rst_i |=> cnt_reg == sbrg_pkg::DIV_RESET && !baud_tick_o)
    else $error("bad reset count");

  // ---------------------------------------------------------------
  // checks: select and idle
  // ---------------------------------------------------------------
  idle_hold_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see R9
    (!active && !lo_wr && !hi_wr) |=> (!baud_tick_o && $stable(cnt_reg)))
    else $error("divider ran while idle");

  idle_tick_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see R9
    !active |=> !baud_tick_o)
    else $error("tick while idle");

  one_enable_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see R10
    $onehot0({uart_en_o, spi_en_o, i2c_en_o}))
    else $error("more than one controller enabled");

  sel_none_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see R12
    (serial_select_field_i == sbrg_pkg::SBRG_SEL_NONE) |-> !uart_en_o && !spi_en_o && !i2c_en_o)
    else $error("enable with nothing selected");

  sel_uart_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see R12
    (serial_select_field_i == sbrg_pkg::SBRG_SEL_UART) |-> uart_en_o)
    else $error("uart not enabled");

  sel_spi_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see R12
    (serial_select_field_i == sbrg_pkg::SBRG_SEL_SPI) |-> spi_en_o)
    else $error("spi not enabled");

  sel_i2c_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see R12
    (serial_select_field_i == sbrg_pkg::SBRG_SEL_I2C) |-> i2c_en_o)
    else $error("i2c not enabled");

  i2c_no_tick_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see R8
    i2c_en_o |-> !uart_tick_o && !spi_tick_o)
    else $error("baud tick routed while i2c selected");

  uart_route_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see R8
    uart_tick_o |-> baud_tick_o && uart_en_o)
    else $error("uart tick without baud tick");

  spi_route_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see R8
    spi_tick_o |-> baud_tick_o && spi_en_o)
    else $error("spi tick without baud tick");

endmodule : sbrg_baud_divider
`default_nettype wire

// [sbrg_ser_model.sv]
`default_nettype none
module sbrg_ser_model (
  // clock
  input wire logic sys_clk_i,
  // ticks
  input wire logic uart_tick_i,
  input wire logic spi_tick_i,
  // tick counts
  output var logic [15:0] uart_n_o,
  output var logic [15:0] spi_n_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] uart_n = 16'h0000;
  logic [15:0] spi_n = 16'h0000;
  assign uart_n_o = uart_n;
  assign spi_n_o = spi_n;
  // each tick is one bit time
  always @(posedge sys_clk_i)
  begin
    uart_n <= uart_n + 16'(uart_tick_i);
    spi_n <= spi_n + 16'(spi_tick_i);
  end
endmodule : sbrg_ser_model
`default_nettype wire

// [sbrg_baud_divider_tb_top.sv]
`default_nettype none
module sbrg_baud_divider_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [1:0] sel = 2'b00;
  logic lw = 1'b0, dl = 1'b0, dh = 1'b0;
  logic [7:0] wd = 8'h00, lcr, lo, hi;
  logic [15:0] cnt, un, sn, b;
  logic ue, se, ie, tk, ut, st;
  int err_count = 0, compares = 0;
  sbrg_baud_divider dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .serial_select_field_i(sel),
    .lcr_wr_i(lw), .lcr_wdata_i(wd), .divisor_low_wr_i(dl), .divisor_high_wr_i(dh),
    .divisor_wdata_i(wd), .line_control_register_o(lcr), .divisor_low_byte_o(lo),
    .divisor_high_byte_o(hi), .count_o(cnt), .uart_en_o(ue), .spi_en_o(se), .i2c_en_o(ie),
    .baud_tick_o(tk), .uart_tick_o(ut), .spi_tick_o(st));
  sbrg_ser_model far (.sys_clk_i(sys_clk_i), .uart_tick_i(ut), .spi_tick_i(st),
    .uart_n_o(un), .spi_n_o(sn));
  initial
  begin
    forever #50 sys_clk_i = ~sys_clk_i;
  end
  task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
    compares++;
    if (s !== e)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : cyc
  // strobe code: 1 line control, 2 low byte, 4 high byte
  task automatic wr(input logic [2:0] w, input logic [7:0] d);
    @(posedge sys_clk_i);
    {dh, dl, lw} <= w;
    wd <= d;
    @(posedge sys_clk_i);
    {dh, dl, lw} <= 3'h0;
    #1;
  endtask : wr
  task automatic stop_test;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test
  initial
  begin
    cyc(2000);
    err_count++;
    stop_test;
  end
  initial
  begin
    repeat (10) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    #1;
    check("lcr", 16'(lcr), 16'h0000);
    check("div", {hi, lo}, 16'h0002);
    check("cnt", cnt, 16'h0002);
    wr(3'h2, 8'h09);
    check("locked", {hi, lo}, 16'h0002);
    wr(3'h1, 8'h80);
    check("open", 16'(lcr), 16'h0080);
    wr(3'h2, 8'h04);
    check("reload", cnt, 16'h0004);
    b = un;
    cyc(5);
    check("idle cnt", cnt, 16'h0004);
    check("idle tick", un - b, 16'h0000);
    $display("test access done");
    @(posedge sys_clk_i);
    sel <= sbrg_pkg::SBRG_SEL_UART;
    for (int i = 0; i < 20 && tk !== 1'b1; i++) cyc(1);
    for (int i = 4; i > 0; i--)
    begin
      check("down", cnt, 16'(i));
      cyc(1);
    end
    b = un;
    cyc(40);
    check("rate", un - b, 16'h000A);
    check("no spi", sn, 16'h0000);
    wr(3'h4, 8'h01);
    check("high", cnt, 16'h0104);
    wr(3'h4, 8'h00);
    wr(3'h2, 8'h01);
    cyc(2);
    b = un;
    cyc(20);
    check("bypass", un - b, 16'h0014);
    $display("test count done");
    for (int s = 0; s < 4; s++)
    begin
      @(posedge sys_clk_i);
      sel <= 2'(s);
      cyc(1);
      check("en", 16'({ie, se, ue}), 16'(s == 0 ? 0 : 1 << (s - 1)));
    end
    @(posedge sys_clk_i);
    sel <= sbrg_pkg::SBRG_SEL_SPI;
    cyc(2);
    b = sn;
    cyc(10);
    check("spi tick", sn - b, 16'h000A);
    wr(3'h2, 8'h02);
    b = sn;
    cyc(10);
    check("spi div2", sn - b, 16'h0004);
    wr(3'h1, 8'h00);
    wr(3'h2, 8'h55);
    check("relock", 16'(lo), 16'h0002);
    $display("test select done");
    stop_test;
  end
endmodule : sbrg_baud_divider_tb_top
`default_nettype wire
